// ### inc/lcdc_cfg.svh
// Constants of the LCD controller command port: opcodes, limits, timing
`ifndef LCDC_CFG_SVH
`define LCDC_CFG_SVH

// Clock and initialisation time
`define LCDC_CLK_NS     50
`define LCDC_INIT_NS    1000
`define LCDC_INIT_CYC   ((`LCDC_INIT_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)
`define LCDC_CNT_W      5
`define LCDC_CNT_LAST   5'h01

// Command opcodes (upper nibble, upper seven bits or whole byte)
`define LCDC_OP_COL_HI  4'h1
`define LCDC_OP_COL_LO  4'h0
`define LCDC_OP_PAGE    4'hb
`define LCDC_OP_ADC     7'h50
`define LCDC_OP_POL     7'h53
`define LCDC_OP_DISP    7'h57
`define LCDC_OP_RMW     8'he0
`define LCDC_OP_END     8'hee
`define LCDC_OP_RST     8'he2

// Address space
`define LCDC_COL_MAX    8'h83
`define LCDC_COL_ZERO   8'h00
`define LCDC_COL_STEP   8'h01
`define LCDC_PAGE_MAX   4'h8
`define LCDC_PAGE_ZERO  4'h0
`define LCDC_COLS       11'h084
`define LCDC_RAM_DEPTH  1188
`define LCDC_IDX_W      11

// Read answers
`define LCDC_NO_DATA    8'h00
`define LCDC_ST_LOW     4'h0

`endif

// ### inc/lcdc_pkg.sv
// State types of the LCD controller command port: core and column counter
package lcdc_pkg;
  `include "lcdc_cfg.svh"

  // Operating state of the core
  typedef enum logic {LCDC_RUN, LCDC_INIT} lcdc_state_t;

  // Whole state of the command core
  typedef struct packed {
    lcdc_state_t             state;
    logic                    busy;
    logic [`LCDC_CNT_W-1:0]  cnt;
    logic [3:0]              page;
    logic                    adc_normal;
    logic                    disp_off;
    logic                    pol_rev;
    logic                    rmw;
    logic                    dummy;
    logic [7:0]              rd_data;
    logic [7:0]              rd_latch;
    logic                    ser_s1;
    logic                    ser_s2;
  } lcdc_core_t;

  // Whole state of the column counter
  typedef struct packed {
    logic [7:0] col;
    logic [7:0] saved;
  } lcdc_col_t;

endpackage : lcdc_pkg

// ### logic/lcdc_col_ctr.sv
// Column address counter with nibble loads, saturation and save/restore
`timescale 1ns/1ps
`include "lcdc_cfg.svh"
module lcdc_col_ctr
  import lcdc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Controls
  input  wire logic       clear_i,
  input  wire logic       load_hi_i,
  input  wire logic       load_lo_i,
  input  wire logic [3:0] nib_i,
  input  wire logic       step_i,
  input  wire logic       save_i,
  input  wire logic       restore_i,
  // Column address
  output logic      [7:0] col_o
);

  lcdc_col_t st_r;   // Registered state
  lcdc_col_t st_nxt; // Next state

  // Next column: clear, load, restore, then step
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt.col = `LCDC_COL_ZERO;
    end else if (load_hi_i) begin
      st_nxt.col = {nib_i, st_r.col[3:0]};
    end else if (load_lo_i) begin
      st_nxt.col = {st_r.col[7:4], nib_i};
    end else if (restore_i) begin
      st_nxt.col = st_r.saved;
    end else if (step_i && st_r.col < `LCDC_COL_MAX) begin
      // Plain RAM order, mapping setting not involved
      st_nxt.col = st_r.col + `LCDC_COL_STEP;
    end
    // At the ceiling the column simply holds
    if (save_i) begin
      st_nxt.saved = st_r.col;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign col_o = st_r.col;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  col_sat_a: assert property (
    step_i && !clear_i && !load_hi_i && !load_lo_i && !restore_i
    && st_r.col == `LCDC_COL_MAX |=> st_r.col == `LCDC_COL_MAX)
    else $error("column left its ceiling");

  col_inc_a: assert property (
    step_i && !clear_i && !load_hi_i && !load_lo_i && !restore_i
    && st_r.col < `LCDC_COL_MAX |=> st_r.col == $past(st_r.col) + 8'h01)
    else $error("column did not advance by one");

  col_hi_a: assert property (
    load_hi_i && !clear_i |=> st_r.col[7:4] == $past(nib_i))
    else $error("upper nibble not loaded");

endmodule : lcdc_col_ctr

// ### logic/lcdc_core.sv
// Command port of a dot-matrix LCD controller: status, column, RAM access
//
// Overview of operation
// - Column loaded as upper and lower nibble
// - Each RAM access advances column by one, except reads in read-modify-write
// - Column advance stops at 83H
// - Column end never changes the page
// - Busy bit high while initialising; commands ignored
// - Status bit 6 shows segment direction
// - Status bit 5 shows display off
// - Status bit 4 shows reset in progress
// - Data write stores byte, then advances
// - Data read returns byte, then advances
// - First read after column load is dummy
// - No data reads in serial mode
// - Direction command selects segment mapping
// - Advance follows RAM order, not mapping
// - Polarity command selects pixel sense
// - Polarity change leaves RAM untouched
// - Reset clears column and page
// - Read-modify-write: reads do not advance
`timescale 1ns/1ps
`include "lcdc_cfg.svh"
module lcdc_core
  import lcdc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Host command port
  input  wire logic       cmd_data_select_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_stb_i,
  input  wire logic       rd_stb_i,
  output logic      [7:0] rd_data_o,
  // Interface strap pin
  input  wire logic       serial_mode_i,
  // Display settings towards the drivers
  output logic            busy_o,
  output logic            adc_normal_o,
  output logic            display_off_o,
  output logic            pol_reverse_o,
  output logic      [3:0] page_o,
  output logic      [7:0] col_o
);

  lcdc_core_t st_r;   // Registered state
  lcdc_core_t st_nxt; // Next state

  // Reset image: display off, normal mapping, initialising
  localparam lcdc_core_t CORE_RST = '{
    state:      LCDC_INIT,
    busy:       1'b1,
    cnt:        `LCDC_CNT_W'(`LCDC_INIT_CYC),
    page:       `LCDC_PAGE_ZERO,
    adc_normal: 1'b1,
    disp_off:   1'b1,
    pol_rev:    1'b0,
    rmw:        1'b0,
    dummy:      1'b0,
    rd_data:    `LCDC_NO_DATA,
    rd_latch:   `LCDC_NO_DATA,
    ser_s1:     1'b0,
    ser_s2:     1'b0
  };

  // Display RAM, one byte per page and column
  logic [7:0]             ram [0:`LCDC_RAM_DEPTH-1];
  logic [`LCDC_IDX_W-1:0] ram_idx;   // Linear RAM address
  logic                   col_ok;    // Column inside the array
  logic [7:0]             ram_q;     // Byte at current address
  logic                   ram_we;    // RAM write this cycle

  // Column counter controls
  logic                   col_clear; // Back to column zero
  logic                   col_ld_hi; // Load upper nibble
  logic                   col_ld_lo; // Load lower nibble
  logic                   col_step;  // Advance by one
  logic                   col_save;  // Remember on entering the mode
  logic                   col_rest;  // Return on leaving the mode
  logic [7:0]             col;       // Current column

  // Command decode helpers
  logic                   cmd_wr;    // Accepted command write
  logic                   data_wr;   // Accepted data write
  logic                   data_rd;   // Data read of any kind

  // Address of the current byte
  always_comb begin
    ram_idx = `LCDC_IDX_W'(st_r.page) * `LCDC_COLS + `LCDC_IDX_W'(col);
    col_ok  = (col <= `LCDC_COL_MAX);
    ram_q   = col_ok ? ram[ram_idx] : `LCDC_NO_DATA;
  end

  // Strobe qualification; writes are not taken while busy, reads are
  always_comb begin
    cmd_wr  = wr_stb_i && !cmd_data_select_i && !st_r.busy;
    data_wr = wr_stb_i && cmd_data_select_i && !st_r.busy;
    data_rd = rd_stb_i && cmd_data_select_i;
  end

  // Command interpreter
  always_comb begin
    st_nxt    = st_r;
    col_clear = 1'b0;
    col_ld_hi = 1'b0;
    col_ld_lo = 1'b0;
    col_step  = 1'b0;
    col_save  = 1'b0;
    col_rest  = 1'b0;
    ram_we    = 1'b0;

    // Two-stage capture of the strap pin
    st_nxt.ser_s1 = serial_mode_i;
    st_nxt.ser_s2 = st_r.ser_s1;

    // Initialisation countdown
    case (st_r.state)
      LCDC_INIT: begin
        if (st_r.cnt == `LCDC_CNT_LAST) begin
          st_nxt.state = LCDC_RUN;
          st_nxt.busy  = 1'b0;
          st_nxt.cnt   = '0;
        end else begin
          st_nxt.cnt = st_r.cnt - `LCDC_CNT_LAST;
        end
      end
      LCDC_RUN: begin
        // Ready for commands
        st_nxt.busy = 1'b0;
      end
      default: begin
        // Unknown state: back to the countdown, count not reloaded
        st_nxt.state = LCDC_INIT;
        st_nxt.busy  = 1'b1;
      end
    endcase

    // Reads
    if (rd_stb_i && !cmd_data_select_i) begin
      // Status byte, low nibble fixed at zero
      st_nxt.rd_data = {st_r.busy,
                        st_r.adc_normal,
                        st_r.disp_off,
                        st_r.state == LCDC_INIT,
                        `LCDC_ST_LOW};
    end else if (data_rd && (st_r.busy || st_r.ser_s2)) begin
      // No data path in serial mode or while busy
      st_nxt.rd_data = `LCDC_NO_DATA;
    end else if (data_rd && st_r.dummy) begin
      // Stale latch goes out, address stays
      st_nxt.rd_data = st_r.rd_latch;
      st_nxt.dummy   = 1'b0;
    end else if (data_rd) begin
      st_nxt.rd_data  = ram_q;
      st_nxt.rd_latch = ram_q;
      col_step        = !st_r.rmw;
    end

    // Data write: store, then advance
    if (data_wr) begin
      ram_we   = col_ok;
      col_step = 1'b1;
    end

    // Command writes
    if (cmd_wr) begin
      if (wr_data_i[7:4] == `LCDC_OP_COL_HI) begin
        // Column load is not allowed inside the mode
        col_ld_hi    = !st_r.rmw;
        st_nxt.dummy = !st_r.rmw;
      end else if (wr_data_i[7:4] == `LCDC_OP_COL_LO) begin
        col_ld_lo    = !st_r.rmw;
        st_nxt.dummy = !st_r.rmw;
      end else if (wr_data_i[7:4] == `LCDC_OP_PAGE) begin
        // Page moves here and on soft reset; out-of-range values ignored
        if (wr_data_i[3:0] <= `LCDC_PAGE_MAX) begin
          st_nxt.page = wr_data_i[3:0];
        end
      end else if (wr_data_i[7:1] == `LCDC_OP_ADC) begin
        st_nxt.adc_normal = !wr_data_i[0];
      end else if (wr_data_i[7:1] == `LCDC_OP_POL) begin
        // Only the drive sense changes, RAM is left alone
        st_nxt.pol_rev = wr_data_i[0];
      end else if (wr_data_i[7:1] == `LCDC_OP_DISP) begin
        st_nxt.disp_off = !wr_data_i[0];
      end else if (wr_data_i == `LCDC_OP_RMW) begin
        st_nxt.rmw = 1'b1;
        col_save   = !st_r.rmw;
      end else if (wr_data_i == `LCDC_OP_END) begin
        st_nxt.rmw = 1'b0;
        col_rest   = st_r.rmw;
      end else if (wr_data_i == `LCDC_OP_RST) begin
        // Soft reset: addresses, mode and init countdown, RAM kept
        col_clear    = 1'b1;
        st_nxt.page  = `LCDC_PAGE_ZERO;
        st_nxt.rmw   = 1'b0;
        st_nxt.dummy = 1'b0;
        st_nxt.state = LCDC_INIT;
        st_nxt.busy  = 1'b1;
        st_nxt.cnt   = `LCDC_CNT_W'(`LCDC_INIT_CYC);
      end
      // Other opcodes belong to blocks outside this one
    end
  end

  // State register; hardware reset loads the reset image
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= CORE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Display RAM write port, no reset on contents
  always_ff @(posedge clock_i) begin
    if (ram_we) begin
      ram[ram_idx] <= wr_data_i;
    end
  end

  // Column address counter
  lcdc_col_ctr u_col (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (col_clear),
    .load_hi_i (col_ld_hi),
    .load_lo_i (col_ld_lo),
    .nib_i     (wr_data_i[3:0]),
    .step_i    (col_step),
    .save_i    (col_save),
    .restore_i (col_rest),
    .col_o     (col)
  );

  // Outputs, all straight from flip-flops
  assign rd_data_o     = st_r.rd_data;
  assign busy_o        = st_r.busy;
  assign adc_normal_o  = st_r.adc_normal;
  assign display_off_o = st_r.disp_off;
  assign pol_reverse_o = st_r.pol_rev;
  assign page_o        = st_r.page;
  assign col_o         = col;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Lower nibble load accepted outside the mode
  sequence col_load_s;
    cmd_wr && wr_data_i[7:4] == `LCDC_OP_COL_LO && !st_r.rmw;
  endsequence

  // Data read in parallel mode while idle
  sequence data_rd_s;
    data_rd && !st_r.busy && !st_r.ser_s2;
  endsequence

  status_fmt_a: assert property (
    rd_stb_i && !cmd_data_select_i
    |=> rd_data_o[3:0] == 4'h0 && rd_data_o[7] == $past(busy_o)
        && rd_data_o[6] == $past(adc_normal_o)
        && rd_data_o[5] == $past(display_off_o))
    else $error("status byte malformed");

  busy_block_a: assert property (
    busy_o && wr_stb_i && !cmd_data_select_i
    |=> $stable(adc_normal_o) && $stable(pol_reverse_o)
        && $stable(display_off_o))
    else $error("command taken while busy");

  adc_cmd_a: assert property (
    cmd_wr && wr_data_i[7:1] == `LCDC_OP_ADC
    |=> adc_normal_o == !$past(wr_data_i[0]))
    else $error("direction command not applied");

  pol_cmd_a: assert property (
    cmd_wr && wr_data_i[7:1] == `LCDC_OP_POL
    |=> pol_reverse_o == $past(wr_data_i[0]))
    else $error("polarity command not applied");

  disp_cmd_a: assert property (
    cmd_wr && wr_data_i[7:1] == `LCDC_OP_DISP
    |=> display_off_o == !$past(wr_data_i[0]))
    else $error("display on/off not applied");

  dummy_read_a: assert property (
    col_load_s ##1 !data_rd ##1 data_rd_s
    |=> $stable(col_o) && !st_r.dummy)
    else $error("first read after load was not dummy");

  rmw_read_a: assert property (
    data_rd_s and (st_r.rmw && !wr_stb_i) |=> $stable(col_o))
    else $error("read advanced column in modify mode");

  page_hold_a: assert property (
    (data_wr && col_o == `LCDC_COL_MAX) |=> $stable(page_o))
    else $error("page moved at column end");

  soft_rst_a: assert property (
    cmd_wr && wr_data_i == `LCDC_OP_RST
    |=> col_o == 8'h00 && page_o == 4'h0 && busy_o ##1 busy_o)
    else $error("reset command did not clear addresses");

  // Data read that delivers a real byte
  sequence real_rd_s;
    data_rd && !st_r.busy && !st_r.ser_s2 && !st_r.dummy;
  endsequence

  // Low nibble of a column load lands as sent
  col_lo_a: assert property (
    col_load_s |=> col_o[3:0] == $past(wr_data_i[3:0]))
    else $error("lower nibble not loaded");

  // Data write advances the column below the ceiling
  wr_step_a: assert property (
    data_wr && col_o < `LCDC_COL_MAX
    |=> col_o == $past(col_o) + `LCDC_COL_STEP)
    else $error("data write did not advance column");

  // Real read outside the mode advances the column
  rd_step_a: assert property (
    real_rd_s and (!st_r.rmw && col_o < `LCDC_COL_MAX)
    |=> col_o == $past(col_o) + `LCDC_COL_STEP)
    else $error("data read did not advance column");

  // Real read hands over the byte at the address
  rd_byte_a: assert property (
    real_rd_s |=> rd_data_o == $past(ram_q))
    else $error("data read returned wrong byte");

  // Serial strap: data reads give nothing, column holds
  ser_rd_a: assert property (
    data_rd && st_r.ser_s2
    |=> rd_data_o == `LCDC_NO_DATA && $stable(col_o))
    else $error("data read answered in serial mode");

  // Busy ends when the countdown reaches its last step
  busy_drop_a: assert property (
    busy_o && st_r.cnt == `LCDC_CNT_LAST |=> !busy_o)
    else $error("busy did not end on time");

  // Page moves only through its own command or the reset command
  page_cmd_a: assert property (
    !cmd_wr |=> $stable(page_o))
    else $error("page moved without a command");

  // Status bit 4 follows initialisation
  init_bit_a: assert property (
    rd_stb_i && !cmd_data_select_i |=> rd_data_o[4] == $past(busy_o))
    else $error("reset flag wrong in status");

endmodule : lcdc_core

// ### dv/lcdc_host.sv
// Host processor model driving the LCD controller command port
`timescale 1ns/1ps
module lcdc_host (
  // Clock
  input  wire logic       clock_i,
  // Command port towards the controller
  output logic            cmd_data_select_o,
  output logic      [7:0] wr_data_o,
  output logic            wr_stb_o,
  output logic            rd_stb_o,
  input  wire logic [7:0] rd_data_i
);
  // Idle bus at time zero
  initial begin
    cmd_data_select_o = 1'b0;
    wr_data_o         = 8'h00;
    wr_stb_o          = 1'b0;
    rd_stb_o          = 1'b0;
  end

  // One-cycle write; released data bus shows the inverse, not stale data
  task automatic wr(input logic cds, input logic [7:0] d);
    @(posedge clock_i);
    cmd_data_select_o <= cds;
    wr_data_o         <= d;
    wr_stb_o          <= 1'b1;
    @(posedge clock_i);
    wr_stb_o          <= 1'b0;
    wr_data_o         <= ~d;
    // Let the write settle before the caller looks at outputs
    #1;
  endtask : wr

  // One-cycle read; answer taken in the cycle after the strobe
  task automatic rd(input logic cds, output logic [7:0] d);
    @(posedge clock_i);
    cmd_data_select_o <= cds;
    rd_stb_o          <= 1'b1;
    @(posedge clock_i);
    rd_stb_o          <= 1'b0;
    #1 d = rd_data_i;
  endtask : rd

  // Column load as upper then lower nibble, one idle cycle between the strobes
  task automatic col_set(input logic [7:0] c);
    wr(1'b0, {4'h1, c[7:4]});
    wr(1'b0, {4'h0, c[3:0]});
  endtask : col_set

  // Column load followed by the throwaway read the host must discard
  task automatic col_skip(input logic [7:0] c);
    logic [7:0] junk;
    col_set(c);
    rd(1'b1, junk);
  endtask : col_skip
endmodule : lcdc_host

// ### dv/testbench.sv
// Self-checking bench of the LCD controller command core
`timescale 1ns/1ps
module testbench;
  import lcdc_pkg::*;

  // Ordinary command case: opcode, status byte, {pol, page}
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] st;
    logic [7:0] pp;
  } lcdc_row_t;

  localparam lcdc_row_t ROWS [10] = '{
    '{8'ha1, 8'h20, 8'h00}, '{8'ha0, 8'h60, 8'h00},
    '{8'haf, 8'h40, 8'h00}, '{8'hae, 8'h60, 8'h00},
    '{8'haf, 8'h40, 8'h00}, '{8'ha7, 8'h40, 8'h10},
    '{8'ha6, 8'h40, 8'h00}, '{8'hb8, 8'h40, 8'h08},
    '{8'hb9, 8'h40, 8'h08}, '{8'hb3, 8'h40, 8'h03}};

  // Clock, reset, strap and port wires
  logic       clock_i;
  logic       rst_n_i;
  logic       serial_mode_i;
  logic       cds;
  logic [7:0] wr_data;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rd_data_o;
  logic       busy_o;
  logic       adc_normal_o;
  logic       display_off_o;
  logic       pol_reverse_o;
  logic [3:0] page_o;
  logic [7:0] col_o;
  int         bad_count;
  int         check_count;
  logic [7:0] d;
  int         n;

  // Design under test
  lcdc_core i_lcdc_core (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_data_select_i(cds),
    .wr_data_i(wr_data), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb),
    .rd_data_o(rd_data_o), .serial_mode_i(serial_mode_i),
    .busy_o(busy_o), .adc_normal_o(adc_normal_o),
    .display_off_o(display_off_o), .pol_reverse_o(pol_reverse_o),
    .page_o(page_o), .col_o(col_o));

  // Host model on the far side of the command port
  lcdc_host i_lcdc_host (
    .clock_i(clock_i), .cmd_data_select_o(cds), .wr_data_o(wr_data),
    .wr_stb_o(wr_stb), .rd_stb_o(rd_stb), .rd_data_i(rd_data_o));

  // 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Poll busy until low, counting edges, bounded
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (busy_o !== 1'b0 && cnt < 100) begin
      @(posedge clock_i);
      #1 cnt++;
    end
  endtask : wait_idle

  // Hold reset, check reset image, release and time the busy span
  task automatic do_reset(input int cyc);
    int c;
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (cyc) @(posedge clock_i);
    #1 chk({busy_o, adc_normal_o, display_off_o, pol_reverse_o, page_o},
           8'he0);
    chk(col_o, 8'h00);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    wait_idle(c);
    chk(c[7:0], 8'h14);
  endtask : do_reset

  // Print counts and the verdict, then stop
  task automatic give_verdict();
    $display("Checks made: %0d, mismatches: %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hang
  initial begin
    #(3000 * 50);
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rst_n_i       = 1'b0;
    serial_mode_i = 1'b0;
    bad_count     = 0;
    check_count   = 0;
    do_reset(6);
    // Setting commands, read back through status and outputs
    foreach (ROWS[i]) begin
      i_lcdc_host.wr(1'b0, ROWS[i].cmd);
      i_lcdc_host.rd(1'b0, d);
      chk(d, ROWS[i].st);
      chk({3'h0, pol_reverse_o, page_o}, ROWS[i].pp);
    end
    // Stream writes up to the column ceiling, reversed mapping, pol on
    i_lcdc_host.wr(1'b0, 8'ha1);
    i_lcdc_host.wr(1'b0, 8'ha7);
    i_lcdc_host.col_set(8'h82);
    chk(col_o, 8'h82);
    i_lcdc_host.wr(1'b1, 8'h5a);
    chk(col_o, 8'h83);
    i_lcdc_host.wr(1'b1, 8'hc3);
    chk(col_o, 8'h83);
    chk({4'h0, page_o}, 8'h03);
    i_lcdc_host.wr(1'b0, 8'ha6);
    // Read back after the throwaway read
    i_lcdc_host.col_skip(8'h82);
    chk(col_o, 8'h82);
    i_lcdc_host.rd(1'b1, d);
    chk(d, 8'h5a);
    chk(col_o, 8'h83);
    i_lcdc_host.rd(1'b1, d);
    chk(d, 8'hc3);
    chk(col_o, 8'h83);
    // Read-modify-write: reads hold the column, end restores it
    i_lcdc_host.col_skip(8'h82);
    i_lcdc_host.wr(1'b0, 8'he0);
    i_lcdc_host.rd(1'b1, d);
    chk(d, 8'h5a);
    chk(col_o, 8'h82);
    i_lcdc_host.wr(1'b1, 8'h66);
    chk(col_o, 8'h83);
    i_lcdc_host.wr(1'b0, 8'hee);
    chk(col_o, 8'h82);
    i_lcdc_host.rd(1'b1, d);
    chk(d, 8'h66);
    // Serial strap: data reads give nothing and hold the column
    @(posedge clock_i);
    serial_mode_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    i_lcdc_host.col_skip(8'h82);
    i_lcdc_host.rd(1'b1, d);
    chk(d, 8'h00);
    chk(col_o, 8'h82);
    @(posedge clock_i);
    serial_mode_i <= 1'b0;
    // Hardware reset in mid-run
    do_reset(2);
    // Soft reset: busy, init flag, refused commands
    i_lcdc_host.col_set(8'h45);
    i_lcdc_host.wr(1'b0, 8'hb2);
    i_lcdc_host.wr(1'b0, 8'he2);
    chk({busy_o, 3'h0, page_o}, 8'h80);
    chk(col_o, 8'h00);
    i_lcdc_host.rd(1'b0, d);
    chk(d, 8'hf0);
    i_lcdc_host.wr(1'b0, 8'h15);
    chk(col_o, 8'h00);
    wait_idle(n);
    chk(n[7:0], 8'h10);
    i_lcdc_host.rd(1'b0, d);
    chk(d, 8'h60);
    give_verdict();
  end
endmodule : testbench
